// ===== gpt_pkg.sv
/*
 * Package for the general purpose 16-bit timer: register byte addresses,
 * byte lanes, command codes, reset values and interrupt source code.
 * Assumes a 32-bit AHB-Lite register bus with command and period bytes sharing one word.
 */
package gpt_pkg;
	// Word address of the timer register word
	localparam logic [11:0] TIMER_WORD_ADDR = 12'h084;
	// Word address of an extra status word holding the interrupt source code
	localparam logic [11:0] IRQ_SRC_ADDR = 12'h080;
	// Byte lanes inside the timer word
	localparam int CMD_LSB = 0;
	localparam int RSVD_LSB = 8;
	localparam int PLO_LSB = 16;
	localparam int PHI_LSB = 24;
	// Position of the channel 0 source code in the interrupt word
	localparam int SRC_LSB = 8;
	// Reset values, command byte read values and interrupt source codes
	localparam logic [15:0] PERIOD_RST = 16'h0000;
	localparam logic [7:0] CMD_RD_PEND = 8'h01;
	localparam logic [7:0] CMD_RD_NONE = 8'h00;
	localparam logic [2:0] SRC_TIMER = 3'h7;
	localparam logic [2:0] SRC_NONE = 3'h0;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	// Internal counting clock rate versus system clock
	localparam int INT_CLK_MHZ = 125;
	localparam int SYS_CLK_MHZ = 200;
	// Command codes
	typedef enum logic [3:0] {
		CMD_NOP = 4'h0,
		CMD_IRQ_EN = 4'h1,
		CMD_IRQ_DIS = 4'h2,
		CMD_ONESHOT = 4'h3,
		CMD_RETRIG = 4'h4,
		CMD_INT_CLK = 4'h5,
		CMD_EXT_CLK = 4'h6,
		CMD_ROUTE = 4'h7,
		CMD_UNROUTE = 4'h8,
		CMD_START = 4'h9,
		CMD_STOP = 4'hA,
		CMD_RESET = 4'hB
	} gpt_cmd_t;
endpackage

// ===== gpt_timer.sv
/*
 * General purpose 16-bit timer with AHB-Lite register slave.
 * Assumes one clock domain; the external timer clock pin and the
 * internal counting tick are sampled or derived on clk_sys, so the
 * external clock must run below a quarter of 200 MHz.
 */
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Count internal 125 MHz ticks or external clock pin, chosen by command.
// - Period N is high byte then low byte, bit 0 least significant.
// - Period byte reads return programmed period, not live count.
// - Period clears at reset, kept by timer reset command; here a reset command written while stopped loads the period bytes of its word.
// - Commands go in bits 3:0 and self-clear; never read back.
// - Command register reads 0x01 only if enabled and pending, else 0x00.
// - Reset and reset command: irq off, retrig, internal, unrouted, stopped.
// - Code 0001 enables, code 0010 disables timer interrupt.
// - Code 0011 selects one-shot, code 0100 selects re-triggerable.
// - Code 0101 internal clock, code 0110 external pin clock.
// - Code 0111 routes output to pin zero, 1000 removes routing.
// - 1010 stops, 1011 resets, 1100 to 1111 do nothing.
// - High phase floor(N/2), low phase the remainder.
// - One-shot output high once started, low after N clocks, stays low.
// - One-shot restart before time-out reloads; after time-out ignored.
// - Started one-shot ignores period writes and other commands except stop and reset.
// - Re-triggerable output high P, low Q, repeats until stop forces high.
// - Running re-triggerable ignores start, period writes, other commands except stop and reset.
// - Routed output forces pin zero to output, general pin control ignored.
// - Interrupt at one-shot time-out, each rising edge in re-triggerable.
// - Pending cleared only by command read or reset command.
// - Pending interrupt shows source code 111 when no UART source.
module gpt_timer (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Timer clock pin
	input wire logic timerExtClockPin,
	// Channel 0 UART source code from the UART core
	input wire logic [2:0] uartCh0Source,
	// General pin control for multipurpose pin zero
	input wire logic mpLevelIn,
	input wire logic mpDirOut,
	input wire logic mpPinIn,
	// Multipurpose pin zero
	output logic multipurposePinZeroOut,
	output logic multipurposePinZeroOe,
	// Timer status
	output logic timerOut,
	output logic timerIrq
);
	logic [15:0] periodReg;
	logic irqEnReg, oneShotReg, extClkReg, routeReg, runReg;
	logic pendReg, timedOutReg, phaseReg;
	logic [15:0] countReg;
	logic [7:0] tickAccReg;
	logic tickReg;
	logic [8:0] tickSum;
	logic extSync1Reg, extSync2Reg, extPrevReg;
	logic dpWriteReg, dpReadReg;
	logic [11:0] dpAddrReg;
	logic cmdWrite, cmdRead, perWrite, countTick, blocked;
	logic [3:0] cmd;
	logic [15:0] highLen, lowLen, curLen;
	logic timeoutEv, riseEv;

	// Address phase capture; always zero wait, OKAY
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			dpWriteReg <= 1'b0;
			dpReadReg <= 1'b0;
			dpAddrReg <= 12'h000;
		end else if (hready) begin
			dpWriteReg <= hsel && htrans[1] && hwrite;
			dpReadReg <= hsel && htrans[1] && !hwrite;
			dpAddrReg <= {haddr[11:2], 2'b00};
		end
	end
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Decoded accesses
	assign cmd = hwdata[gpt_pkg::CMD_LSB +: 4];
	assign cmdWrite = dpWriteReg && dpAddrReg == gpt_pkg::TIMER_WORD_ADDR;
	assign cmdRead = dpReadReg && dpAddrReg == gpt_pkg::TIMER_WORD_ADDR;
	// Programming is locked while started
	assign blocked = runReg;
	assign perWrite = cmdWrite && !blocked;

	// Read data, combinational from stored state and the live uartCh0Source input
	always_comb begin
		hrdata = 32'h00000000;
		if (dpReadReg && dpAddrReg == gpt_pkg::TIMER_WORD_ADDR) begin
			hrdata[gpt_pkg::PHI_LSB +: 8] = periodReg[15:8];
			hrdata[gpt_pkg::PLO_LSB +: 8] = periodReg[7:0];
			hrdata[gpt_pkg::CMD_LSB +: 8] = (irqEnReg && pendReg) ?
				gpt_pkg::CMD_RD_PEND : gpt_pkg::CMD_RD_NONE;
		end else if (dpReadReg && dpAddrReg == gpt_pkg::IRQ_SRC_ADDR) begin
			hrdata[gpt_pkg::SRC_LSB +: 3] = (uartCh0Source != gpt_pkg::SRC_NONE)
				? uartCh0Source : ((irqEnReg && pendReg) ? gpt_pkg::SRC_TIMER
				: gpt_pkg::SRC_NONE);
		end
	end

	// Period bytes, high and low, loaded by any command word write while stopped, reset command included
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			periodReg <= gpt_pkg::PERIOD_RST;
		end else if (perWrite) begin
			periodReg <= {hwdata[gpt_pkg::PHI_LSB +: 8],
				hwdata[gpt_pkg::PLO_LSB +: 8]};
		end
	end

	// Mode bits updated by commands
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irqEnReg <= 1'b0;
			oneShotReg <= 1'b0;
			extClkReg <= 1'b0;
			routeReg <= 1'b0;
		end else if (cmdWrite) begin
			if (cmd == gpt_pkg::CMD_RESET) begin
				irqEnReg <= 1'b0;
				oneShotReg <= 1'b0;
				extClkReg <= 1'b0;
				routeReg <= 1'b0;
			end else if (!blocked) begin
				unique case (cmd)
					gpt_pkg::CMD_IRQ_EN: irqEnReg <= 1'b1;
					gpt_pkg::CMD_IRQ_DIS: irqEnReg <= 1'b0;
					gpt_pkg::CMD_ONESHOT: oneShotReg <= 1'b1;
					gpt_pkg::CMD_RETRIG: oneShotReg <= 1'b0;
					gpt_pkg::CMD_INT_CLK: extClkReg <= 1'b0;
					gpt_pkg::CMD_EXT_CLK: extClkReg <= 1'b1;
					gpt_pkg::CMD_ROUTE: routeReg <= 1'b1;
					gpt_pkg::CMD_UNROUTE: routeReg <= 1'b0;
					default: ;
				endcase
			end
		end
	end

	// Accumulator sum one bit wider so the carry past 255 is kept
	assign tickSum = {1'b0, tickAccReg} + 9'(gpt_pkg::INT_CLK_MHZ);

	// External pin synchroniser and internal 125 MHz tick accumulator
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			extSync1Reg <= 1'b0;
			extSync2Reg <= 1'b0;
			extPrevReg <= 1'b0;
			tickAccReg <= 8'h00;
			tickReg <= 1'b0;
		end else begin
			extSync1Reg <= timerExtClockPin;
			extSync2Reg <= extSync1Reg;
			extPrevReg <= extSync2Reg;
			if (tickSum >= 9'(gpt_pkg::SYS_CLK_MHZ)) begin
				tickAccReg <= 8'(tickSum - 9'(gpt_pkg::SYS_CLK_MHZ));
				tickReg <= 1'b1;
			end else begin
				tickAccReg <= tickSum[7:0];
				tickReg <= 1'b0;
			end
		end
	end
	assign countTick = extClkReg ? (extSync2Reg && !extPrevReg)
		: tickReg;

	// Phase lengths
	assign highLen = {1'b0, periodReg[15:1]};
	assign lowLen = periodReg - highLen;
	assign curLen = phaseReg ? lowLen : highLen;
	assign timeoutEv = runReg && oneShotReg && !timedOutReg && countTick
		&& countReg + 16'h0001 >= periodReg;
	assign riseEv = runReg && !oneShotReg && countTick && phaseReg
		&& countReg + 16'h0001 >= curLen;

	// Counter, run state, output phase
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			runReg <= 1'b0;
			countReg <= gpt_pkg::COUNT_RST;
			phaseReg <= 1'b0;
			timedOutReg <= 1'b0;
		end else if (cmdWrite && (cmd == gpt_pkg::CMD_RESET ||
			cmd == gpt_pkg::CMD_STOP)) begin
			runReg <= 1'b0;
			countReg <= gpt_pkg::COUNT_RST;
			phaseReg <= 1'b0;
			timedOutReg <= 1'b0;
		end else if (cmdWrite && cmd == gpt_pkg::CMD_START &&
			(!runReg || (oneShotReg && !timedOutReg))) begin
			runReg <= 1'b1;
			countReg <= gpt_pkg::COUNT_RST;
			phaseReg <= 1'b0;
		end else if (runReg && countTick) begin
			if (oneShotReg) begin
				if (timeoutEv) begin
					timedOutReg <= 1'b1;
					phaseReg <= 1'b1;
				end else if (!timedOutReg) begin
					countReg <= countReg + 16'h0001;
				end
			end else if (countReg + 16'h0001 >= curLen) begin
				countReg <= gpt_pkg::COUNT_RST;
				phaseReg <= !phaseReg;
			end else begin
				countReg <= countReg + 16'h0001;
			end
		end
	end

	// Pending flag: set wins over read clear
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pendReg <= 1'b0;
		end else if (timeoutEv || riseEv) begin
			pendReg <= 1'b1;
		end else if (cmdRead || (cmdWrite && cmd == gpt_pkg::CMD_RESET)) begin
			pendReg <= 1'b0;
		end
	end

	// Outputs and pin zero takeover
	assign timerOut = !phaseReg;
	assign timerIrq = irqEnReg && pendReg;
	assign multipurposePinZeroOut = routeReg ? timerOut : mpLevelIn;
	assign multipurposePinZeroOe = routeReg ? 1'b1 : mpDirOut;

	// Tick count since start in one-shot, kept apart from the counter
	logic [15:0] shotTicksReg;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			shotTicksReg <= 16'h0000;
		end else if (!runReg || (cmdWrite && cmd == gpt_pkg::CMD_START)) begin
			shotTicksReg <= 16'h0000;
		end else if (oneShotReg && !timedOutReg && countTick) begin
			shotTicksReg <= shotTicksReg + 16'h0001;
		end
	end

	// Tick count since start or last rise in re-triggerable operation
	logic [15:0] riseTicksReg;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			riseTicksReg <= 16'h0000;
		end else if (!runReg || riseEv) begin
			riseTicksReg <= 16'h0000;
		end else if (!oneShotReg && countTick) begin
			riseTicksReg <= riseTicksReg + 16'h0001;
		end
	end

	// Register read checks
	chk_onecmd_read: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		cmdRead |-> hrdata[15:1] == 15'h0000
		&& hrdata[0] == (irqEnReg && pendReg))
		else $error("command byte read not 0 or 1");
	chk_src_timer: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		dpReadReg && dpAddrReg == gpt_pkg::IRQ_SRC_ADDR
		&& uartCh0Source == gpt_pkg::SRC_NONE && timerIrq
		|-> hrdata[gpt_pkg::SRC_LSB +: 3] == gpt_pkg::SRC_TIMER)
		else $error("timer source code missing");
	chk_src_uart: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		dpReadReg && dpAddrReg == gpt_pkg::IRQ_SRC_ADDR
		&& uartCh0Source != gpt_pkg::SRC_NONE
		|-> hrdata[gpt_pkg::SRC_LSB +: 3] == uartCh0Source)
		else $error("uart source not given priority");

	// Command and lock checks
	chk_reset_cmd: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		cmdWrite && cmd == gpt_pkg::CMD_RESET && !timeoutEv && !riseEv
		|=> !runReg && !irqEnReg
		&& !oneShotReg && !extClkReg && !routeReg && !pendReg)
		else $error("reset command left state");
	chk_period_keep: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		cmdWrite && runReg |=> $stable(periodReg))
		else $error("period changed while running");
	chk_mode_locked: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		cmdWrite && runReg && cmd != gpt_pkg::CMD_RESET
		|=> $stable(irqEnReg) && $stable(oneShotReg)
		&& $stable(extClkReg) && $stable(routeReg))
		else $error("mode changed while running");
	chk_start_zero: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		cmdWrite && cmd == gpt_pkg::CMD_START && !runReg |=> runReg
		&& countReg == gpt_pkg::COUNT_RST)
		else $error("start did not begin from zero");

	// Pending flag checks
	chk_pend_hold: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		pendReg && !cmdRead && !cmdWrite |=> pendReg)
		else $error("pending lost without clear");
	chk_read_clear: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		cmdRead && !timeoutEv && !riseEv |=> !pendReg)
		else $error("command read left pending set");
	chk_irq_set: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		timeoutEv || riseEv |=> pendReg)
		else $error("event did not set pending");

	// Timing checks against the independent tick counts, internal tick gap and count bounds
	chk_oneshot_len: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		timeoutEv |-> shotTicksReg == periodReg - 16'h0001)
		else $error("one-shot timeout at wrong tick");
	chk_retrig_len: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		riseEv |-> riseTicksReg == periodReg - 16'h0001)
		else $error("re-trigger rise at wrong tick");
	chk_tick_gap: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		!tickReg ##1 !tickReg |=> tickReg)
		else $error("internal tick gap too long");
	chk_shot_bound: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		runReg && oneShotReg |-> countReg < periodReg)
		else $error("one-shot count past period");
	chk_phase_bound: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		runReg && !oneShotReg |-> countReg < curLen)
		else $error("phase count past its length");

	// Output level checks
	chk_stop_high: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		cmdWrite && cmd == gpt_pkg::CMD_STOP |=> timerOut)
		else $error("stop did not force output high");
	chk_stopped_high: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		!runReg |-> timerOut)
		else $error("stopped timer output low");
	chk_oneshot_low: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		runReg && oneShotReg && timedOutReg && !cmdWrite |=> !timerOut)
		else $error("one-shot output rose after timeout");
	chk_timeout_phase: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		timedOutReg |-> phaseReg)
		else $error("timed out but output high");

	// Pin zero checks
	chk_route_pin: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		routeReg |-> multipurposePinZeroOe &&
		multipurposePinZeroOut == timerOut)
		else $error("pin not taken by timer");
	chk_pin_free: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		!routeReg |-> multipurposePinZeroOe == mpDirOut &&
		multipurposePinZeroOut == mpLevelIn)
		else $error("pin not returned to general control");
endmodule

`default_nettype wire

// ===== gpt_timer_tb.sv
/* Self-checking bench for gpt_timer: bus tasks, ext clock ticks, checks.
 * Assumes gpt_pkg and gpt_timer are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module gpt_timer_tb;
	logic clk_sys, resetn, hsel, hwrite, extClk, mpLevelIn, mpDirOut, mpPinIn;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize, uartSrc;
	logic hreadyout, hresp, pinOut, pinOe, timerOut, timerIrq;
	logic [15:0] per;
	int miscompares, comparisons, n, k;
	localparam logic [31:0] TW = 32'h0000_0084;
	localparam logic [31:0] SW = 32'h0000_0080;
	gpt_timer uut (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .timerExtClockPin(extClk),
		.uartCh0Source(uartSrc), .mpLevelIn(mpLevelIn), .mpDirOut(mpDirOut),
		.mpPinIn(mpPinIn), .multipurposePinZeroOut(pinOut),
		.multipurposePinZeroOe(pinOe), .timerOut(timerOut),
		.timerIrq(timerIrq));
	// Clock generator
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// Watchdog against hangs
	initial begin
		#200000;
		miscompares++;
		wrap_up();
	end
	// Verdict and end of run
	task wrap_up;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Compare seen against expected
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Single AHB-Lite word transfer; read data lands in rd
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'b010;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rd = hrdata;
		@(negedge clk_sys);
	endtask
	// Command write; the word always carries the tracked period
	task cmd(input logic [3:0] c);
		bus(1'b1, TW, {per, 12'h000, c});
	endtask
	// External clock pulses, nine system cycles each
	task tick(input int cnt);
		repeat (cnt) begin
			@(posedge clk_sys);
			extClk <= 1'b1;
			repeat (4) @(posedge clk_sys);
			extClk <= 1'b0;
			repeat (4) @(posedge clk_sys);
		end
		@(negedge clk_sys);
	endtask
	// Count pulses until the timer output reaches a level
	task until_lvl(input logic lvl, output int c);
		c = 0;
		while (timerOut !== lvl && c < 100) begin
			tick(1);
			c++;
		end
	endtask
	function automatic logic [31:0] hi_phase(input logic [15:0] v);
		return {17'h0, v[15:1]};
	endfunction
	// Main sequence
	initial begin
		resetn = 1'b0;
		{hsel, hwrite, extClk, mpPinIn} = 4'h0;
		{haddr, hwdata, htrans, hsize, uartSrc, per} = '0;
		k = $urandom(49);
		mpLevelIn = 1'($urandom);
		mpDirOut = 1'($urandom);
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		@(negedge clk_sys);
		chk(timerOut, 1'b1);
		chk({pinOe, pinOut}, {mpDirOut, mpLevelIn});
		bus(1'b0, TW, 0);
		chk(rd, 32'h0);
		$display("reset test done");
		for (k = 0; k < 8; k++) begin
			per = (k == 0) ? 16'h0002 : (k == 1) ? 16'hFFFF
				: 16'($urandom_range(65535, 2));
			cmd(4'hC + k[3:0] % 4);
			bus(1'b0, TW, 0);
			chk(rd, {per, 16'h0000});
		end
		cmd(4'h7);
		chk({pinOe, pinOut}, 2'b11);
		cmd(4'h8);
		chk({pinOe, pinOut}, {mpDirOut, mpLevelIn});
		$display("register test done");
		per = 16'(3 + $urandom_range(5));
		cmd(4'h1);
		cmd(4'h3);
		cmd(4'h6);
		cmd(4'h9);
		until_lvl(1'b0, n);
		chk(n, per);
		chk(timerIrq, 1'b1);
		bus(1'b0, SW, 0);
		chk(rd[10:8], 3'h7);
		bus(1'b1, TW, 32'h0002_0002);
		bus(1'b0, TW, 0);
		chk(rd, {per, 16'h0001});
		bus(1'b0, TW, 0);
		chk(rd, {per, 16'h0000});
		cmd(4'h9);
		tick(per + 1);
		chk(timerOut, 1'b0);
		cmd(4'hA);
		chk(timerOut, 1'b1);
		cmd(4'h9);
		tick(per - 1);
		cmd(4'h9);
		until_lvl(1'b0, n);
		chk(n, per);
		cmd(4'hA);
		$display("one-shot test done");
		cmd(4'hB);
		bus(1'b0, TW, 0);
		chk(rd, {per, 16'h0000});
		per = 16'(5 + $urandom_range(6));
		cmd(4'h1);
		cmd(4'h6);
		cmd(4'h9);
		until_lvl(1'b0, n);
		chk(n, hi_phase(per));
		until_lvl(1'b1, n);
		chk(n, per - hi_phase(per));
		chk(timerIrq, 1'b1);
		cmd(4'h3);
		until_lvl(1'b0, n);
		chk(n, hi_phase(per));
		cmd(4'hA);
		chk({timerOut, timerIrq}, 2'b11);
		uartSrc <= 3'h2;
		bus(1'b0, SW, 0);
		chk(rd[10:8], 3'h2);
		uartSrc <= 3'h0;
		cmd(4'hB);
		chk(timerIrq, 1'b0);
		$display("re-trigger test done");
		per = 16'h0002;
		cmd(4'h3);
		cmd(4'h9);
		k = 0;
		while (timerOut !== 1'b0 && k < 50) begin
			@(negedge clk_sys);
			k++;
		end
		chk(timerOut, 1'b0);
		$display("internal clock test done");
		wrap_up();
	end
endmodule
`default_nettype wire
